// ===== hw/pdre_map.svh
// Constants of the delayed read engine: command codes, boundaries and reset values.
// Contract
// - Every read is queued as delayed and the initiator gets a retry.
// - Capture address, command and parity; byte enables when initiator data-ready.
// - Head request goes to the target bus only after posted writes drain.
// - Target-bus read uses the exact captured address and command.
// - Non-prefetch drives captured byte enables; prefetch drives all zero.
// - Target retry makes the engine repeat the read until data or error.
// - After data then master end or disconnect, no further fetch attempts.
// - Attempts count against a programmable limit; reaching it reports system error.
// - Retry-limit system error drives the pin only when its enable is set.
// - Returned data goes into the read data buffer facing the initiator.
// - One DWORD accepted every clock; no master wait states.
// - Data goes out only when fetched, at buffer head, writes ordered.
// - Memory read, line and multiple match each other.
// - Disconnect with the last DWORD; leftover data is discarded on early stop.
// - Flow-through starts when repeat takes prefetch data while fetch runs.
// - Flow-through ends on initiator stop, 4KB boundary or full buffer.
// - Empty flow-through buffer disconnects the initiator with data.
// - After that, timeout discards leftovers; discard at once if others wait.
// - Master timeout runs while completion waits; expiry discards, may signal error.
// - Up to four outstanding delayed reads are held.
// - A read matching a queued one is not queued again.
// - Prefetch stops at boundary from command and cache line size.
// - I/O, config and non-prefetch memory reads move exactly one DWORD.
`ifndef PDRE_MAP_SVH
`define PDRE_MAP_SVH
`define PDRE_CMD_IO_RD     4'h2
`define PDRE_CMD_MEM_RD    4'h6
`define PDRE_CMD_CFG_RD    4'ha
`define PDRE_CMD_MEM_RDM   4'hc
`define PDRE_CMD_MEM_RDL   4'he
`define PDRE_DTQ_DEPTH     4
`define PDRE_RDB_DEPTH     4
`define PDRE_BND_DEF_LINE  11'h010
`define PDRE_BND_DEF_MULT  11'h020
`define PDRE_BND_FLOW      11'h400
`define PDRE_RETRY_LIM_DEF 32'h0100_0000
`define PDRE_MTO_DEF       16'h8000
`endif

// ===== hw/pdre_pkg.sv
// Types shared by the delayed read engine.
`default_nettype none
package pdre_pkg;
	typedef struct packed {
		logic [31:0] addr;
		logic [3:0]  cmd;
		logic        par;
		logic        pf;
	} pdre_req_t;
	typedef struct packed {
		logic [31:0] addr;
		logic [3:0]  cmd;
		logic        par;
		logic        pf;
		logic [3:0]  be;
	} pdre_entry_t;
	typedef enum logic [1:0] {
		PDRE_I_IDLE = 2'b00,
		PDRE_I_BE   = 2'b01,
		PDRE_I_XFER = 2'b10
	} pdre_ist_t;
	typedef enum logic [1:0] {
		PDRE_M_IDLE = 2'b00,
		PDRE_M_ADDR = 2'b01,
		PDRE_M_DATA = 2'b10,
		PDRE_M_DONE = 2'b11
	} pdre_mst_t;
endpackage
`default_nettype wire

// ===== hw/pdre_engine.sv
// Delayed read engine: request queue, target-bus master, read data buffer and delivery.
`include "pdre_map.svh"
`default_nettype none

// ==========================================================
// Read data buffer
module pdre_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 4
) (
	input  wire logic             clk,       // Clock.
	input  wire logic             reset,     // Asynchronous reset.
	input  wire logic             flush,     // Drop all contents.
	input  wire logic             in_valid,  // Write request.
	output logic                  in_ready,  // Space available.
	input  wire logic [WIDTH-1:0] in_data,   // Write data.
	output logic                  out_valid, // Data available.
	input  wire logic             out_ready, // Read request.
	output logic      [WIDTH-1:0] out_data,  // Head data.
	output logic [$clog2(DEPTH):0] count     // Words held.
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic             push;
	logic             pop;

	// Handshakes on both sides.
	assign in_ready  = (count != (AW + 1)'(DEPTH));
	assign out_valid = (count != '0);
	assign push      = in_valid && in_ready && !flush;
	assign pop       = out_valid && out_ready && !flush;
	assign out_data  = mem[rd_ptr];

	// Storage carries no reset; only the pointers and count need a defined state.
	always_ff @(posedge clk)
	begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

	// Pointers and occupancy.
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end
		else if (flush)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		end
	end
endmodule

// ==========================================================
// Engine top
module pdre_engine (
	input  wire logic              clk,            // 10 MHz bus clock.
	input  wire logic              reset,          // Asynchronous reset, active high.
	input  wire logic              ini_start,      // Initiator address phase, one cycle.
	input  wire pdre_pkg::pdre_req_t ini_req,      // Address phase contents.
	input  wire logic              ini_frame,      // Initiator still in its transaction.
	input  wire logic              ini_irdy,       // Initiator data-ready.
	input  wire logic [3:0]        ini_be_n,       // First data phase byte enables.
	output logic                   ini_retry,      // Target retry, one cycle.
	output logic                   ini_trdy,       // Read data valid.
	output logic [31:0]            ini_data,       // Read data.
	output logic                   ini_disc,       // Disconnect with this data.
	output logic                   ini_abort,      // Target abort of the repeat.
	input  wire logic              pw_empty,       // No posted write ahead.
	input  wire logic [7:0]        cache_line,     // Cache line size in DWORDs.
	input  wire logic [31:0]       retry_limit,    // Attempt limit.
	input  wire logic [15:0]       mto_init,       // Master timeout reload.
	input  wire logic              serr_en,        // System error enable.
	output logic                   tgt_req,        // Target bus request.
	input  wire logic              tgt_gnt,        // Target bus grant.
	output logic                   tgt_frame,      // Transaction in progress.
	output logic                   tgt_addr_phase, // Address phase marker.
	output logic [31:0]            tgt_addr,       // Address.
	output logic [3:0]             tgt_cmd,        // Bus command.
	output logic                   tgt_par,        // Address parity.
	output logic                   tgt_irdy,       // Master data-ready.
	output logic [3:0]             tgt_be_n,       // Byte enables.
	input  wire logic              tgt_trdy,       // Target data valid.
	input  wire logic              tgt_stop,       // Target stop.
	input  wire logic              tgt_abort,      // Target or master abort.
	input  wire logic [31:0]       tgt_data,       // Target data.
	output logic                   primary_system_error_n, // System error, low one cycle.
	output logic                   dtq_full,       // All entries used.
	output logic                   flow_through    // Flow-through active.
);
	import pdre_pkg::*;

	pdre_entry_t  dtq [`PDRE_DTQ_DEPTH];
	logic [3:0]   dtq_vld;
	logic [1:0]   head;
	logic [1:0]   tail;
	logic [2:0]   dtq_cnt;
	pdre_ist_t    ist;
	pdre_mst_t    mst;
	pdre_entry_t  hd;
	pdre_entry_t  cap;
	logic [3:0]   hit_vec;
	logic         hit;
	logic         hit_head;
	logic         head_err;
	logic         abandon;
	logic         partial;
	logic         mstop;
	logic [31:0]  attempts;
	logic [29:0]  cur_dw;
	logic [15:0]  mto;
	logic         pop_entry;
	logic         discard;
	logic         rdb_in_ready;
	logic         rdb_out_valid;
	logic [31:0]  rdb_out_data;
	logic [2:0]   rdb_cnt;
	logic         rdb_push;
	logic         rdb_pop;
	logic         last_word;
	logic [10:0]  bnd;
	logic         at_bnd;
	logic         will_full;
	logic         req_pf;

	// Memory read, line and multiple fall in one class for matching.
	function automatic logic [3:0] cmd_class(input logic [3:0] c);
		cmd_class = (c == `PDRE_CMD_MEM_RDL || c == `PDRE_CMD_MEM_RDM) ? `PDRE_CMD_MEM_RD : c;
	endfunction

	assign hd = dtq[head];

	// Line and multiple reads always prefetch; I/O and configuration reads never do.
	assign req_pf = ini_req.cmd == `PDRE_CMD_MEM_RDL || ini_req.cmd == `PDRE_CMD_MEM_RDM
		|| (ini_req.cmd == `PDRE_CMD_MEM_RD && ini_req.pf);

	// Match the incoming request against every held entry.
	genvar g;
	generate
		for (g = 0; g < `PDRE_DTQ_DEPTH; g++)
		begin : g_match
			assign hit_vec[g] = dtq_vld[g] && dtq[g].addr == ini_req.addr
				&& cmd_class(dtq[g].cmd) == cmd_class(ini_req.cmd);
		end
	endgenerate
	assign hit      = |hit_vec;
	assign hit_head = hit_vec[head];

	// Prefetch boundary in DWORDs; a lone DWORD for non-prefetchable reads.
	always_comb
	begin
		if (flow_through)
			bnd = `PDRE_BND_FLOW;
		else if (!hd.pf)
			bnd = 11'h001;
		else if (cache_line == 8'h00 || cache_line == 8'h10)
			bnd = (hd.cmd == `PDRE_CMD_MEM_RDM) ? `PDRE_BND_DEF_MULT : `PDRE_BND_DEF_LINE;
		else
			bnd = (hd.cmd == `PDRE_CMD_MEM_RDM) ? {2'b00, cache_line, 1'b0}
				: {3'b000, cache_line};
	end

	// The next DWORD starts a new aligned block, so this one is the last.
	assign at_bnd    = ((cur_dw[10:0] + 11'h001) & (bnd - 11'h001)) == 11'h000;
	assign rdb_push  = mst == PDRE_M_DATA && tgt_trdy;
	assign rdb_pop   = ist == PDRE_I_XFER && ini_irdy && rdb_out_valid && !head_err;
	assign will_full = rdb_cnt == 3'(`PDRE_RDB_DEPTH - 1) && !rdb_pop;
	assign last_word = rdb_cnt == 3'h1 && !rdb_push;

	// Leftovers go when abandoned, stale, or others wait behind them.
	assign discard = mst == PDRE_M_DONE && ist != PDRE_I_XFER && dtq_vld[head]
		&& (abandon || (partial && dtq_cnt > 3'h1) || mto == 16'h0001);
	assign pop_entry = discard
		|| (ist == PDRE_I_XFER && mst == PDRE_M_DONE && rdb_pop && last_word)
		|| (ist == PDRE_I_XFER && head_err);

	pdre_fifo #(
		.WIDTH (32),
		.DEPTH (`PDRE_RDB_DEPTH)
	) read_data_buffer (
		.clk       (clk),
		.reset     (reset),
		.flush     (pop_entry),
		.in_valid  (rdb_push),
		.in_ready  (rdb_in_ready),
		.in_data   (tgt_data),
		.out_valid (rdb_out_valid),
		.out_ready (rdb_pop),
		.out_data  (rdb_out_data),
		.count     (rdb_cnt)
	);

	// ==========================================================
	// Delayed transaction queue
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			dtq_vld <= 4'h0;
			head    <= 2'h0;
			tail    <= 2'h0;
			dtq_cnt <= 3'h0;
			cap     <= '0;
			for (int i = 0; i < `PDRE_DTQ_DEPTH; i++)
				dtq[i] <= '0;
		end
		else
		begin
			if (ist == PDRE_I_IDLE && ini_start)
				cap <= '{ini_req.addr, ini_req.cmd, ini_req.par, req_pf, 4'h0};
			if (ist == PDRE_I_BE && ini_irdy)
			begin
				dtq[tail]     <= '{cap.addr, cap.cmd, cap.par, cap.pf, ini_be_n};
				dtq_vld[tail] <= 1'b1;
				tail          <= tail + 2'h1;
			end
			if (pop_entry)
			begin
				dtq_vld[head] <= 1'b0;
				head          <= head + 2'h1;
			end
			dtq_cnt <= dtq_cnt + {2'b00, ist == PDRE_I_BE && ini_irdy} - {2'b00, pop_entry};
		end
	end

	// Full flag for the outside; reserved space holds four entries.
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			dtq_full <= 1'b0;
		else
			dtq_full <= (dtq_cnt + {2'b00, ist == PDRE_I_BE && ini_irdy}
				- {2'b00, pop_entry}) == 3'(`PDRE_DTQ_DEPTH);
	end

	// ==========================================================
	// Initiator side: retry, capture, delivery
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			ist          <= PDRE_I_IDLE;
			ini_retry    <= 1'b0;
			ini_trdy     <= 1'b0;
			ini_data     <= 32'h0000_0000;
			ini_disc     <= 1'b0;
			ini_abort    <= 1'b0;
			flow_through <= 1'b0;
			abandon      <= 1'b0;
			partial      <= 1'b0;
		end
		else
		begin
			ini_retry <= 1'b0;
			ini_trdy  <= 1'b0;
			ini_disc  <= 1'b0;
			ini_abort <= 1'b0;
			if (pop_entry)
			begin
				abandon      <= 1'b0;
				partial      <= 1'b0;
				flow_through <= 1'b0;
			end
			unique case (ist)
				PDRE_I_IDLE:
				begin
					if (ini_start)
					begin
						// Hand out data only from the head, completed or still prefetching, with writes drained.
						if (hit_head && pw_empty && (head_err || (rdb_out_valid
							&& (mst == PDRE_M_DONE || (hd.pf && mst == PDRE_M_DATA)))))
						begin
							ist          <= PDRE_I_XFER;
							flow_through <= mst == PDRE_M_DATA;
							partial      <= 1'b0;
						end
						else if (hit || dtq_cnt == 3'(`PDRE_DTQ_DEPTH))
							ini_retry <= 1'b1;
						else
							ist <= PDRE_I_BE;
					end
				end
				PDRE_I_BE:
				begin
					if (ini_irdy)
					begin
						ini_retry <= 1'b1;
						ist       <= PDRE_I_IDLE;
					end
				end
				PDRE_I_XFER:
				begin
					if (head_err)
					begin
						ini_abort <= 1'b1;
						ist       <= PDRE_I_IDLE;
					end
					else if (!ini_frame)
					begin
						// Initiator quit early: whatever is left is thrown away.
						abandon <= 1'b1;
						ist     <= PDRE_I_IDLE;
					end
					else if (rdb_pop)
					begin
						ini_trdy <= 1'b1;
						ini_data <= rdb_out_data;
						if (last_word)
						begin
							ini_disc <= 1'b1;
							partial  <= mst != PDRE_M_DONE;
							ist      <= PDRE_I_IDLE;
						end
					end
				end
				default:
					ist <= PDRE_I_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Target side master
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			mst            <= PDRE_M_IDLE;
			tgt_req        <= 1'b0;
			tgt_frame      <= 1'b0;
			tgt_addr_phase <= 1'b0;
			tgt_addr       <= 32'h0000_0000;
			tgt_cmd        <= 4'h0;
			tgt_par        <= 1'b0;
			tgt_irdy       <= 1'b0;
			tgt_be_n       <= 4'hf;
			attempts       <= 32'h0000_0000;
			cur_dw         <= 30'h0000_0000;
			head_err       <= 1'b0;
			mstop          <= 1'b0;
		end
		else
		begin
			tgt_addr_phase <= 1'b0;
			if (pop_entry)
			begin
				mst      <= PDRE_M_IDLE;
				attempts <= 32'h0000_0000;
				head_err <= 1'b0;
				tgt_frame <= 1'b0;
				tgt_irdy  <= 1'b0;
				tgt_req   <= 1'b0;
			end
			else
			begin
				unique case (mst)
					PDRE_M_IDLE:
					begin
						tgt_req <= dtq_vld[head] && pw_empty;
						if (tgt_req && tgt_gnt && pw_empty)
						begin
							mst            <= PDRE_M_ADDR;
							tgt_req        <= 1'b0;
							tgt_frame      <= 1'b1;
							tgt_addr_phase <= 1'b1;
							tgt_addr       <= hd.addr;
							tgt_cmd        <= hd.cmd;
							tgt_par        <= hd.par;
							cur_dw         <= hd.addr[31:2];
							mstop          <= 1'b0;
						end
					end
					PDRE_M_ADDR:
					begin
						mst      <= PDRE_M_DATA;
						tgt_irdy <= 1'b1;
						tgt_be_n <= hd.pf ? 4'h0 : hd.be;
					end
					PDRE_M_DATA:
					begin
						if (tgt_abort)
						begin
							head_err  <= 1'b1;
							mst       <= PDRE_M_DONE;
							tgt_frame <= 1'b0;
							tgt_irdy  <= 1'b0;
						end
						else if (tgt_trdy)
						begin
							mstop  <= 1'b1;
							cur_dw <= cur_dw + 30'h1;
							// End at boundary, full buffer, initiator stop or target stop.
							if (at_bnd || will_full || abandon || tgt_stop)
							begin
								mst       <= PDRE_M_DONE;
								tgt_frame <= 1'b0;
								tgt_irdy  <= 1'b0;
							end
						end
						else if (tgt_stop)
						begin
							tgt_frame <= 1'b0;
							tgt_irdy  <= 1'b0;
							if (mstop)
								mst <= PDRE_M_DONE;
							else if (attempts + 32'h1 >= retry_limit)
							begin
								head_err <= 1'b1;
								mst      <= PDRE_M_DONE;
							end
							else
							begin
								attempts <= attempts + 32'h1;
								mst      <= PDRE_M_IDLE;
							end
						end
					end
					PDRE_M_DONE:
						tgt_be_n <= 4'hf;
					default:
						mst <= PDRE_M_IDLE;
				endcase
			end
		end
	end

	// ==========================================================
	// Master timeout and system error
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			mto <= 16'h0000;
		else if (mst != PDRE_M_DONE || ist == PDRE_I_XFER || !dtq_vld[head] || head_err)
			mto <= mto_init;
		else if (mto != 16'h0001)
			mto <= mto - 16'h0001;
	end

	// Limit failure and timeout discard of an undelivered head both report; the pin obeys its enable.
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			primary_system_error_n <= 1'b1;
		else
			primary_system_error_n <= !(serr_en && ((mst == PDRE_M_DATA && tgt_stop
				&& !tgt_trdy && !tgt_abort && !mstop && attempts + 32'h1 >= retry_limit)
				|| (discard && mto == 16'h0001 && !abandon && !partial)));
	end
endmodule
`default_nettype wire

// ===== dv/pdre_checker.sv
// Port assertions for the delayed read engine.
`default_nettype none
module pdre_checker (
	input wire logic		clk,			// Clock.
	input wire logic		reset,			// Reset.
	input wire logic		pw_empty,		// Writes drained.
	input wire logic		serr_en,		// Error enable.
	input wire logic		tgt_gnt,		// Grant.
	input wire logic		tgt_frame,		// Frame.
	input wire logic		tgt_addr_phase,	// Address phase.
	input wire logic [3:0]	tgt_cmd,		// Command.
	input wire logic		tgt_irdy,		// Master ready.
	input wire logic [3:0]	tgt_be_n,		// Byte enables.
	input wire logic		tgt_trdy,		// Target ready.
	input wire logic		ini_retry,		// Retry.
	input wire logic		ini_trdy,		// Data valid.
	input wire logic		ini_disc,		// Disconnect.
	input wire logic		ini_abort,		// Abort.
	input wire logic		primary_system_error_n	// Error pulse.
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	logic	single_q;
	// ====================
	// I/O and configuration reads are known by command, latched at the address phase and held for its data.
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			single_q <= 1'b0;
		else if (tgt_addr_phase)
			single_q <= tgt_cmd == 4'h2 || tgt_cmd == 4'ha;
	end
	// ====================
	// Target bus steps.
	sequence s_pf_addr;
		tgt_addr_phase && (tgt_cmd == 4'hc || tgt_cmd == 4'he);
	endsequence
	sequence s_one_data;
		single_q && tgt_trdy && tgt_irdy;
	endsequence
	a_write_order: assert property (tgt_addr_phase |-> $past(tgt_gnt && pw_empty))
		else $error("address phase without grant or drained writes");
	a_irdy_follow: assert property (tgt_addr_phase |=> tgt_frame && tgt_irdy)
		else $error("data phase did not follow address");
	a_no_wait: assert property (tgt_frame && !tgt_addr_phase |-> tgt_irdy)
		else $error("master wait state");
	a_be_prefetch: assert property (s_pf_addr |=> tgt_be_n == 4'h0)
		else $error("prefetch byte enables not all on");
	a_one_word: assert property (s_one_data |-> ##[1:2] !tgt_frame)
		else $error("single-word read kept going");
	a_serr_pulse: assert property ($fell(primary_system_error_n) |=> primary_system_error_n)
		else $error("error pulse too long");
	a_serr_gate: assert property (!primary_system_error_n |-> serr_en)
		else $error("error pin while disabled");
	a_disc_data: assert property (ini_disc |-> ini_trdy)
		else $error("disconnect without data");
	a_disc_last: assert property (ini_disc |=> !ini_trdy)
		else $error("data after disconnect");
	a_one_answer: assert property ($onehot0({ini_retry, ini_trdy, ini_abort}))
		else $error("two answers at once");
endmodule
bind pdre_engine pdre_checker u_chk (.clk, .reset, .pw_empty, .serr_en, .tgt_gnt, .tgt_frame,
	.tgt_addr_phase, .tgt_cmd, .tgt_irdy, .tgt_be_n, .tgt_trdy, .ini_retry, .ini_trdy,
	.ini_disc, .ini_abort, .primary_system_error_n);
`default_nettype wire

// ===== dv/pdre_target_model.sv
// Behavioural target on the far bus of the delayed read engine.
`default_nettype none
module pdre_target_model (
	input wire logic		clk,			// Clock.
	input wire logic		reset,			// Reset.
	input wire logic		arm,			// Load retry count.
	input wire logic [3:0]	retries,		// Retries before data.
	input wire logic [3:0]	beats,			// Words before disconnect, 0 for 16.
	input wire logic		fail,			// Abort every attempt.
	input wire logic		slow,			// Wait state between words.
	input wire logic		tgt_req,		// Request.
	output logic			tgt_gnt,		// Grant.
	input wire logic		tgt_frame,		// Frame.
	input wire logic		tgt_addr_phase,	// Address phase.
	input wire logic [31:0]	tgt_addr,		// Address.
	input wire logic		tgt_irdy,		// Master ready.
	output logic			tgt_trdy,		// Data valid.
	output logic			tgt_stop,		// Stop.
	output logic			tgt_abort,		// Abort.
	output logic [31:0]		tgt_data		// Word address as data.
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0]		left;
	logic [3:0]		cnt;
	logic [31:0]	base;
	logic [31:0]	last;
	logic			done;
	logic			tick;
	logic			live;
	logic			go;
	// ====================
	// Answers; done blocks a second answer while the master is still lowering frame.
	assign live = tgt_frame && tgt_irdy && !done;
	assign go = live && left == 4'h0 && !fail && (!slow || tick);
	assign tgt_trdy = go;
	assign tgt_abort = live && fail;
	assign tgt_stop = live && !fail && (left != 4'h0 || (go && cnt + 4'h1 == beats));
	// An idle data bus shows the inverse of its last word, so stale data cannot pass.
	assign tgt_data = go ? base + {26'h0, cnt, 2'b00} : ~last;
	// Grant, attempt and word bookkeeping.
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			tgt_gnt <= 1'b0;
			left <= 4'h0;
			cnt <= 4'h0;
			base <= 32'h0;
			last <= 32'h0;
			done <= 1'b1;
			tick <= 1'b0;
		end
		else
		begin
			tgt_gnt <= tgt_req;
			tick <= !tick;
			if (arm)
				left <= retries;
			else if (tgt_stop && !go && left != 4'h0)
				left <= left - 4'h1;
			if (tgt_addr_phase)
			begin
				base <= tgt_addr;
				cnt <= 4'h0;
				done <= 1'b0;
			end
			else
			begin
				if (go)
				begin
					cnt <= cnt + 4'h1;
					last <= tgt_data;
				end
				if (tgt_stop || tgt_abort)
					done <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ===== dv/test_pci_delayed_read_engine.sv
// Self-checking bench for the delayed read engine.
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
	$display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module test_pci_delayed_read_engine;
	timeunit 1ns;
	timeprecision 1ns;
	import pdre_pkg::*;
	logic clk = 1'b0, reset = 1'b1, ini_start = 1'b0, ini_frame = 1'b0, ini_irdy = 1'b0;
	logic pw_empty = 1'b1, serr_en = 1'b1, arm = 1'b0, fail = 1'b0, slow = 1'b0;
	logic [3:0] ini_be_n = 4'hf, retries = 4'h0, beats = 4'h0, tgt_cmd, tgt_be_n;
	logic [7:0] cache_line = 8'h00;
	pdre_req_t ini_req = '0;
	logic ini_retry, ini_trdy, ini_disc, ini_abort, tgt_req, tgt_gnt, tgt_frame, tgt_par;
	logic tgt_addr_phase, tgt_irdy, tgt_trdy, tgt_stop, tgt_abort, dtq_full, flow_through;
	logic primary_system_error_n, seen_par, be_next = 1'b0, saw_flow = 1'b0;
	logic [31:0] ini_data, tgt_addr, tgt_data, seen_addr;
	logic [3:0] seen_cmd, seen_be;
	int n_errors = 0, n_compared = 0, n_addr = 0, n_serr = 0, kind, n, i;
	// Rows: address, command, prefetchable, line size, target words, words, byte enables.
	logic [63:0] tab [8] = '{64'h00001000_20000150, 64'h00001004_a0000150,
		64'h00001008_60000150, 64'h0000103c_e0000100, 64'h0000107c_c0000100,
		64'h00001100_c0010200, 64'h00001200_e0010100, 64'h00001300_61002200};
	always #50 clk = ~clk;
	pdre_engine u_dut (.clk, .reset, .ini_start, .ini_req, .ini_frame, .ini_irdy, .ini_be_n,
		.ini_retry, .ini_trdy, .ini_data, .ini_disc, .ini_abort, .pw_empty, .cache_line,
		.retry_limit(32'h4), .mto_init(16'h40), .serr_en, .tgt_req, .tgt_gnt, .tgt_frame,
		.tgt_addr_phase, .tgt_addr, .tgt_cmd, .tgt_par, .tgt_irdy, .tgt_be_n, .tgt_trdy,
		.tgt_stop, .tgt_abort, .tgt_data, .primary_system_error_n, .dtq_full, .flow_through);
	pdre_target_model u_tgt (.clk, .reset, .arm, .retries, .beats, .fail, .slow, .tgt_req,
		.tgt_gnt, .tgt_frame, .tgt_addr_phase, .tgt_addr, .tgt_irdy, .tgt_trdy, .tgt_stop,
		.tgt_abort, .tgt_data);
	// ====================
	// Watcher: records each far-bus attempt and counts error pulses.
	always @(negedge clk)
	begin
		if (be_next)
			seen_be = tgt_be_n;
		be_next = tgt_addr_phase === 1'b1;
		if (be_next)
		begin
			n_addr++;
			seen_addr = tgt_addr;
			seen_cmd = tgt_cmd;
			seen_par = tgt_par;
		end
		if (primary_system_error_n === 1'b0)
			n_serr++;
		if (flow_through === 1'b1)
			saw_flow = 1'b1;
	end
	task end_of_test;
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// ====================
	// One initiator attempt; kind 1 retry, 2 disconnect, 3 abort.
	task automatic rd(input logic [31:0] a, input logic [3:0] c, input logic pf);
		int t;
		kind = 0;
		n = 0;
		t = 0;
		@(posedge clk);
		ini_start <= 1'b1;
		ini_req <= '{addr: a, cmd: c, par: ^{a, c}, pf: pf};
		ini_frame <= 1'b1;
		@(posedge clk);
		ini_start <= 1'b0;
		ini_irdy <= 1'b1;
		ini_be_n <= 4'h5;
		while (kind == 0)
		begin
			@(negedge clk);
			if (ini_trdy === 1'b1)
			begin
				`CHK(ini_data, a + 32'(4 * n))
				n++;
			end
			if (ini_retry === 1'b1)
				kind = 1;
			else if (ini_disc === 1'b1)
				kind = 2;
			else if (ini_abort === 1'b1)
				kind = 3;
			else if (++t > 80)
			begin
				n_errors++;
				end_of_test();
			end
		end
		@(posedge clk);
		ini_frame <= 1'b0;
		ini_irdy <= 1'b0;
	endtask
	// Repeats the identical read until something other than a retry comes back.
	task automatic get(input logic [31:0] a, input logic [3:0] c, input logic pf, input int gap);
		for (int r = 0; r < 40; r++)
		begin
			repeat (gap) @(posedge clk);
			rd(a, c, pf);
			if (kind != 1)
				return;
		end
		n_errors++;
		end_of_test();
	endtask
	task automatic setup(input logic [3:0] r, b, input logic f, s);
		@(posedge clk);
		retries <= r;
		beats <= b;
		fail <= f;
		slow <= s;
		arm <= 1'b1;
		@(posedge clk);
		arm <= 1'b0;
		n_addr = 0;
		n_serr = 0;
	endtask
	task automatic wait_serr;
		for (int t = 0; t < 300 && n_serr == 0; t++)
			@(posedge clk);
		if (n_serr == 0)
		begin
			n_errors++;
			end_of_test();
		end
		repeat (10) @(posedge clk);
	endtask
	// Full delayed read: retry first, then the repeat collects the words.
	task automatic run(input logic [31:0] a, input logic [3:0] c, input logic pf,
		input logic [3:0] rc, input int en, input logic [3:0] be, input int na);
		rd(a, c, pf);
		`CHK(kind, 1)
		get(a, rc, pf, 20);
		`CHK(kind, 2)
		`CHK(n, en)
		`CHK(seen_addr, a)
		`CHK(seen_cmd, c)
		`CHK(seen_par, ^{a, c})
		`CHK(seen_be, be)
		`CHK(n_addr, na)
	endtask
	// ====================
	// Main sequence.
	initial
	begin
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		for (i = 0; i < 8; i++)
		begin
			cache_line <= tab[i][23:16];
			setup(4'h0, tab[i][15:12], 1'b0, 1'b0);
			run(tab[i][63:32], tab[i][31:28], tab[i][24], tab[i][31:28], int'(tab[i][11:8]),
				tab[i][7:4], 1);
		end
		setup(4'h0, 4'h0, 1'b0, 1'b0);
		run(32'h203c, 4'he, 1'b0, 4'hc, 1, 4'h0, 1);
		setup(4'h2, 4'h0, 1'b0, 1'b0);
		run(32'h2100, 4'h6, 1'b0, 4'h6, 1, 4'h5, 3);
		setup(4'hf, 4'h0, 1'b0, 1'b0);
		rd(32'h2200, 4'h6, 1'b0);
		wait_serr();
		`CHK(n_addr, 4)
		`CHK(n_serr, 1)
		get(32'h2200, 4'h6, 1'b0, 0);
		`CHK(kind, 3)
		serr_en <= 1'b0;
		setup(4'hf, 4'h0, 1'b0, 1'b0);
		rd(32'h2300, 4'h6, 1'b0);
		repeat (100) @(posedge clk);
		`CHK(n_addr, 4)
		`CHK(n_serr, 0)
		get(32'h2300, 4'h6, 1'b0, 0);
		`CHK(kind, 3)
		serr_en <= 1'b1;
		setup(4'h0, 4'h0, 1'b1, 1'b0);
		rd(32'h2400, 4'h6, 1'b0);
		get(32'h2400, 4'h6, 1'b0, 20);
		`CHK(kind, 3)
		// Writes pending: fill the queue, refuse a fifth, ignore a duplicate.
		setup(4'h0, 4'h0, 1'b0, 1'b0);
		pw_empty <= 1'b0;
		for (i = 0; i < 6; i++)
		begin
			rd(32'h2500 + 32'(4 * (i % 5)), 4'h2, 1'b0);
			`CHK(kind, 1)
		end
		@(negedge clk);
		`CHK(dtq_full, 1'b1)
		`CHK(n_addr, 0)
		@(posedge clk);
		pw_empty <= 1'b1;
		for (i = 0; i < 4; i++)
		begin
			get(32'h2500 + 32'(4 * i), 4'h2, 1'b0, 5);
			`CHK(n, 1)
		end
		repeat (20) @(posedge clk);
		`CHK(n_addr, 4)
		setup(4'h0, 4'h0, 1'b0, 1'b0);
		rd(32'h2600, 4'h2, 1'b0);
		wait_serr();
		`CHK(n_serr, 1)
		rd(32'h2600, 4'h2, 1'b0);
		`CHK(kind, 1)
		get(32'h2600, 4'h2, 1'b0, 20);
		`CHK(n_addr, 2)
		setup(4'h0, 4'h0, 1'b0, 1'b1);
		rd(32'h3000, 4'hc, 1'b0);
		get(32'h3000, 4'hc, 1'b0, 0);
		`CHK(saw_flow, 1'b1)
		`CHK(kind, 2)
		repeat (100) @(posedge clk);
		end_of_test();
	end
endmodule
`default_nettype wire
